//--- common/gtc_pkg.sv
`default_nettype none

package gtc_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses on the APB side.
    // ------------------------------------------------------------------
    localparam int             ADDR_W          = 8;
    localparam logic [7:0]     OFF_COUNT_LOW   = 8'h00;
    localparam logic [7:0]     OFF_COUNT_HIGH  = 8'h04;
    localparam logic [7:0]     OFF_CTRL        = 8'h08;
    localparam logic [7:0]     OFF_GATE        = 8'h0c;
    localparam logic [7:0]     OFF_STATUS      = 8'h10;
    localparam logic [7:0]     OFF_CLEAR       = 8'h14;
    localparam logic [7:0]     OFF_IRQ_EN      = 8'h18;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int             CTRL_ON_BIT     = 0;
    localparam int             CTRL_SYNC_BIT   = 1;
    localparam int             CTRL_OSC_BIT    = 2;
    localparam int             CTRL_PS_LSB     = 4;
    localparam int             CTRL_CS_LSB     = 6;
    localparam int             GATE_EN_BIT     = 0;
    localparam int             GATE_POL_BIT    = 1;
    localparam int             GATE_SRC_LSB    = 2;
    localparam int             STAT_OVF_BIT    = 0;

    // ------------------------------------------------------------------
    // Values after reset and fixed counts.
    // ------------------------------------------------------------------
    localparam logic [7:0]     CTRL_RST        = 8'h00;
    localparam logic [7:0]     GATE_RST        = 8'h00;
    localparam logic [15:0]    COUNT_RST       = 16'h0000;
    localparam logic [15:0]    COUNT_ALL_ONES  = 16'hffff;
    localparam logic [0:0]     IRQ_EN_RST      = 1'b0;
    localparam logic [1:0]     INSTR_PHASE_LAST = 2'h3;

    typedef enum logic [1:0] {
        GTC_SRC_INSTR = 2'b00,
        GTC_SRC_SYS   = 2'b01,
        GTC_SRC_EXT   = 2'b10,
        GTC_SRC_LFOSC = 2'b11
    } gtc_clk_src_e;

    typedef enum logic [1:0] {
        GTC_GATE_PIN  = 2'b00,
        GTC_GATE_CMP1 = 2'b01,
        GTC_GATE_CMP2 = 2'b10,
        GTC_GATE_NONE = 2'b11
    } gtc_gate_src_e;

endpackage : gtc_pkg

`default_nettype wire

//--- common/gtc_tick_if.sv
`default_nettype none

interface gtc_tick_if;
    import gtc_pkg::*;

    gtc_clk_src_e clk_src;
    logic [1:0]   prescale;
    logic         sync_bypass;
    logic         osc_en;
    logic         sleep;
    logic         run;
    logic         restart;
    logic         tick;
    logic         xtal_lvl;

    modport ctrl (output clk_src, prescale, sync_bypass, osc_en, sleep, run, restart,
                  input  tick, xtal_lvl);
    modport gen  (input  clk_src, prescale, sync_bypass, osc_en, sleep, run, restart,
                  output tick, xtal_lvl);
endinterface : gtc_tick_if

`default_nettype wire

//--- design/gtc_tick_gen.sv
`default_nettype none

module gtc_tick_gen
    import gtc_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  external_count_input,
    input  wire logic  low_freq_internal_osc,
    input  wire logic  crystal_in_pin,
    gtc_tick_if.gen    tif
);

    function automatic logic [2:0] div_last(input logic [1:0] ps);
        div_last = 3'((4'h1 << ps) - 4'h1);
    endfunction : div_last

    logic [2:0] s1_reg, s1_next;
    logic [2:0] s2_reg, s2_next;
    logic       st3_reg, st3_next;
    logic       st4_reg, st4_next;
    logic       lf_d_reg, lf_d_next;
    logic [1:0] phase_reg, phase_next;
    logic [2:0] pre_reg, pre_next;
    logic       armed_reg, armed_next;
    logic       sel_lvl, rise_async, rise_sync, fall_ext, raw;

    // ------------------------------------------------------------------
    // Source selection and prescaler.
    // ------------------------------------------------------------------
    always_comb begin
        s1_next    = {low_freq_internal_osc, crystal_in_pin, external_count_input};
        s2_next    = s1_reg;
        sel_lvl    = tif.osc_en ? s2_reg[1] : s2_reg[0];
        st3_next   = sel_lvl;
        st4_next   = st3_reg;
        lf_d_next  = s2_reg[2];
        rise_async = sel_lvl & ~st3_reg;
        rise_sync  = st3_reg & ~st4_reg & ~tif.sleep;
        fall_ext   = ~sel_lvl & st3_reg;
        phase_next = tif.sleep ? phase_reg : 2'(phase_reg + 2'h1);
        armed_next = tif.restart ? 1'b0 : (fall_ext ? 1'b1 : armed_reg);  // RULE6
        unique case (tif.clk_src)
            GTC_SRC_INSTR: raw = (phase_reg == INSTR_PHASE_LAST) & ~tif.sleep;  // RULE4
            GTC_SRC_SYS:   raw = ~tif.sleep;  // RULE4
            GTC_SRC_EXT:   raw = armed_reg & (tif.sync_bypass ? rise_async : rise_sync);  // RULE5 RULE11 RULE14
            GTC_SRC_LFOSC: raw = s2_reg[2] & ~lf_d_reg;  // RULE3
        endcase
        pre_next = pre_reg;
        if (tif.restart) begin
            pre_next = 3'h0;  // RULE8
        end else if (raw & tif.run) begin
            pre_next = (pre_reg == div_last(tif.prescale)) ? 3'h0 : 3'(pre_reg + 3'h1);  // RULE7
        end
    end

    assign tif.tick     = raw & tif.run & ~tif.restart & (pre_reg == div_last(tif.prescale));
    assign tif.xtal_lvl = s2_reg[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg    <= 3'h0;
            s2_reg    <= 3'h0;
            st3_reg   <= 1'b0;
            st4_reg   <= 1'b0;
            lf_d_reg  <= 1'b0;
            phase_reg <= 2'h0;
            pre_reg   <= 3'h0;
            armed_reg <= 1'b0;
        end else begin
            s1_reg    <= s1_next;
            s2_reg    <= s2_next;
            st3_reg   <= st3_next;
            st4_reg   <= st4_next;
            lf_d_reg  <= lf_d_next;
            phase_reg <= phase_next;
            pre_reg   <= pre_next;
            armed_reg <= armed_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sys_every_cycle: assert property (  // RULE4
        tif.clk_src == GTC_SRC_SYS && tif.prescale == 2'h0 && tif.run && !tif.restart && !tif.sleep |-> tif.tick)
        else $error("System clock source missed a count.");
    a_instr_gap: assert property (  // RULE4
        tif.clk_src == GTC_SRC_INSTR && tif.tick |=> !tif.tick [*3])
        else $error("Instruction clock counted faster than one per four cycles.");
    a_div_eight: assert property (  // RULE7
        tif.prescale == 2'h3 && tif.tick |=> !tif.tick [*7])
        else $error("Divide by eight let two counts through too close.");
    a_prescale_clear: assert property (  // RULE8
        tif.restart |=> pre_reg == 3'h0)
        else $error("Prescaler not cleared by a count write.");
    a_fall_first: assert property (  // RULE6
        tif.restart |=> !(tif.clk_src == GTC_SRC_EXT && tif.tick))
        else $error("External count taken without a falling edge first.");
    a_async_sleep: assert property (  // RULE11
        tif.clk_src == GTC_SRC_EXT && tif.sync_bypass && tif.sleep && armed_reg && rise_async
        && tif.run && !tif.restart && tif.prescale == 2'h0 |-> tif.tick)
        else $error("Unsynchronised input failed to count in sleep.");
    a_sync_late: assert property (  // RULE14
        tif.clk_src == GTC_SRC_EXT && !tif.sync_bypass && tif.tick |-> $past(rise_async))
        else $error("Synchronised count not one cycle behind its edge.");

endmodule : gtc_tick_gen

`default_nettype wire

//--- design/gtc_timer.sv
// How it works
// (RULE1) The count is sixteen bits, reached as a low and a high byte, and writing either byte updates it at once.
// (RULE2) The counter is off with counter_on clear, always counts with gate mode off, and is gated otherwise.
// (RULE3) clock_source_select picks the slow internal oscillator, the external pin, the system clock or a quarter of it.
// (RULE4) The instruction clock gives one count per four cycles and the system clock four.
// (RULE5) With the external source a count is taken on each rising edge, synchronised or not.
// (RULE6) External counting needs a falling edge first after enable, after a count write and after switching off.
// (RULE7) prescale_select divides the selected source by one, two, four or eight.
// (RULE8) The prescaler is hidden from software and cleared by a write to either count byte.
// (RULE9) The secondary oscillator runs while secondary_osc_enable is set, sleep included.
// (RULE10) Software may wait for the oscillator by presetting the count to FC00h and waiting for overflow.
// (RULE11) With sync_bypass set the external input skips the synchroniser and keeps counting and interrupting in sleep.
// (RULE12) Reads of either byte always return a consistent value.
// (RULE13) Software should stop the counter before writing it.
// (RULE14) Switching the synchroniser in or out may drop or add one count.
// (RULE15) Gate mode is enabled by gate_mode_enable, sensed by gate_polarity, from a selectable gate source.
// (RULE16) In gate mode the count advances only while the gate equals gate_polarity and holds otherwise.
// (RULE17) A wrap from all ones to zero sets the sticky overflow_flag until software clears it.
`default_nettype none

module gtc_timer
    import gtc_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              external_count_input,
    input  wire logic              low_freq_internal_osc,
    input  wire logic              crystal_in_pin,
    output logic                   crystal_out_pin,
    input  wire logic              gate_input,
    input  wire logic              comparator1_out,
    input  wire logic              comparator2_out,
    input  wire logic              sleep_mode,
    output logic                   irq
);

    // ------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == OFF_COUNT_LOW) || (a == OFF_COUNT_HIGH) || (a == OFF_CTRL)
                   || (a == OFF_GATE) || (a == OFF_STATUS) || (a == OFF_CLEAR) || (a == OFF_IRQ_EN);
    endfunction : addr_mapped

    logic [15:0] count_reg, count_next;
    logic [7:0]  counter_control_reg, counter_control_next;
    logic [7:0]  gate_control_reg, gate_control_next;
    logic        overflow_flag_reg, overflow_flag_next;
    logic        irq_en_reg, irq_en_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        xtal_out_reg, xtal_out_next;
    logic [2:0]  gs1_reg, gs1_next;
    logic [2:0]  gs2_reg, gs2_next;

    logic        access;
    logic        wr_en;
    logic        wr_low;
    logic        wr_high;
    logic        wr_count;
    logic        clr_ovf;
    logic        ovf_event;
    logic        counter_on;
    logic        gate_mode_enable;
    logic        gate_polarity;
    logic        gate_lvl;
    logic        count_enable;
    gtc_gate_src_e gate_src;

    gtc_tick_if tif ();

    gtc_tick_gen u_tick_gen (
        .pclk                  (pclk),
        .presetn               (presetn),
        .external_count_input  (external_count_input),
        .low_freq_internal_osc (low_freq_internal_osc),
        .crystal_in_pin        (crystal_in_pin),
        .tif                   (tif)
    );

    assign access   = psel & penable;
    assign pready   = access;
    assign pslverr  = access & ~addr_mapped(paddr);
    assign wr_en    = access & pwrite & addr_mapped(paddr);
    assign wr_low   = wr_en & (paddr == OFF_COUNT_LOW);
    assign wr_high  = wr_en & (paddr == OFF_COUNT_HIGH);
    assign wr_count = wr_low | wr_high;
    assign clr_ovf  = wr_en & (paddr == OFF_CLEAR) & pwdata[STAT_OVF_BIT];
    assign prdata   = prdata_reg;

    // ------------------------------------------------------------------
    // Gate path.
    // ------------------------------------------------------------------
    // The gate sources are asynchronous to pclk, so each passes two flops.
    always_comb begin
        gs1_next = {comparator2_out, comparator1_out, gate_input};
        gs2_next = gs1_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gs1_reg <= 3'h0;
            gs2_reg <= 3'h0;
        end else begin
            gs1_reg <= gs1_next;
            gs2_reg <= gs2_next;
        end
    end

    assign counter_on       = counter_control_reg[CTRL_ON_BIT];
    assign gate_mode_enable = gate_control_reg[GATE_EN_BIT];
    assign gate_polarity    = gate_control_reg[GATE_POL_BIT];
    assign gate_src         = gtc_gate_src_e'(gate_control_reg[GATE_SRC_LSB +: 2]);

    always_comb begin
        unique case (gate_src)
            GTC_GATE_PIN:  gate_lvl = gs2_reg[0];  // RULE15
            GTC_GATE_CMP1: gate_lvl = gs2_reg[1];
            GTC_GATE_CMP2: gate_lvl = gs2_reg[2];
            GTC_GATE_NONE: gate_lvl = 1'b0;
        endcase
        count_enable = counter_on & (~gate_mode_enable | (gate_lvl == gate_polarity));  // RULE2 RULE16
    end

    // ------------------------------------------------------------------
    // Tick generator control.
    // ------------------------------------------------------------------
    // Turning the counter off also re-arms the falling-edge wait and clears the prescaler.
    always_comb begin
        tif.clk_src     = gtc_clk_src_e'(counter_control_reg[CTRL_CS_LSB +: 2]);  // RULE3
        tif.prescale    = counter_control_reg[CTRL_PS_LSB +: 2];
        tif.sync_bypass = counter_control_reg[CTRL_SYNC_BIT];
        tif.osc_en      = counter_control_reg[CTRL_OSC_BIT];
        tif.sleep       = sleep_mode;
        tif.run         = count_enable;
        tif.restart     = wr_count | ~counter_on;  // RULE6 RULE8
    end

    // ------------------------------------------------------------------
    // Secondary oscillator drive.
    // ------------------------------------------------------------------
    // The amplifier output is the inverted crystal level while enabled; it does not depend
    // on the processor clocks being gated, so it keeps running in sleep.
    always_comb begin
        xtal_out_next = tif.osc_en & ~tif.xtal_lvl;  // RULE9
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_out_reg <= 1'b0;
        end else begin
            xtal_out_reg <= xtal_out_next;
        end
    end

    assign crystal_out_pin = xtal_out_reg;

    // ------------------------------------------------------------------
    // Count, control and interrupt state.
    // ------------------------------------------------------------------
    // A byte write beats a coincident increment so that the written value is exact; software
    // is still expected to stop the counter first.
    always_comb begin
        count_next           = count_reg;
        counter_control_next = counter_control_reg;
        gate_control_next    = gate_control_reg;
        irq_en_next          = irq_en_reg;
        ovf_event            = tif.tick & ~wr_count & (count_reg == COUNT_ALL_ONES);
        if (wr_low) begin
            count_next = {count_reg[15:8], pwdata[7:0]};  // RULE1 RULE13
        end else if (wr_high) begin
            count_next = {pwdata[7:0], count_reg[7:0]};  // RULE1
        end else if (tif.tick) begin
            count_next = 16'(count_reg + 16'h0001);  // RULE1
        end
        if (wr_en && paddr == OFF_CTRL) begin
            counter_control_next = pwdata[7:0];
        end
        if (wr_en && paddr == OFF_GATE) begin
            gate_control_next = pwdata[7:0];  // RULE15
        end
        if (wr_en && paddr == OFF_IRQ_EN) begin
            irq_en_next = pwdata[STAT_OVF_BIT];
        end
        // A new overflow in the clearing cycle keeps the flag set.
        overflow_flag_next = ovf_event | (overflow_flag_reg & ~clr_ovf);  // RULE17 RULE11
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg           <= COUNT_RST;
            counter_control_reg <= CTRL_RST;
            gate_control_reg    <= GATE_RST;
            irq_en_reg          <= IRQ_EN_RST;
            overflow_flag_reg   <= 1'b0;
        end else begin
            count_reg           <= count_next;
            counter_control_reg <= counter_control_next;
            gate_control_reg    <= gate_control_next;
            irq_en_reg          <= irq_en_next;
            overflow_flag_reg   <= overflow_flag_next;
        end
    end

    assign irq = overflow_flag_reg & irq_en_reg;  // RULE11

    // ------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------
    // Read data is captured in the setup cycle from the pclk-domain count, so a byte read
    // never sees a half-updated value even with an unsynchronised source.
    always_comb begin
        prdata_next = prdata_reg;
        if (psel && !penable) begin
            prdata_next = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    OFF_COUNT_LOW:  prdata_next[7:0] = count_reg[7:0];  // RULE12
                    OFF_COUNT_HIGH: prdata_next[7:0] = count_reg[15:8];  // RULE12
                    OFF_CTRL:       prdata_next[7:0] = counter_control_reg;
                    OFF_GATE:       prdata_next[7:0] = gate_control_reg;
                    OFF_STATUS:     prdata_next[STAT_OVF_BIT] = overflow_flag_reg;
                    OFF_IRQ_EN:     prdata_next[STAT_OVF_BIT] = irq_en_reg;
                    default:        prdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wrap;
        tif.tick && !wr_count && count_reg == COUNT_ALL_ONES;
    endsequence

    sequence s_gate_closed;
        counter_on && gate_mode_enable && gate_lvl != gate_polarity && !wr_count;
    endsequence

    a_low_byte_write: assert property (  // RULE1
        wr_low |=> count_reg[7:0] == $past(pwdata[7:0]) && count_reg[15:8] == $past(count_reg[15:8]))
        else $error("Low byte write did not land in the count.");
    a_high_byte_write: assert property (  // RULE1
        wr_high |=> count_reg[15:8] == $past(pwdata[7:0]) && count_reg[7:0] == $past(count_reg[7:0]))
        else $error("High byte write did not land in the count.");
    a_off_holds: assert property (  // RULE2
        !counter_on && !wr_count |=> count_reg == $past(count_reg))
        else $error("Count moved while the counter was off.");
    a_gate_holds: assert property (  // RULE16
        s_gate_closed |=> count_reg == $past(count_reg))
        else $error("Count moved while the gate was closed.");
    a_gate_counts: assert property (  // RULE15
        counter_on && gate_mode_enable && gate_lvl == gate_polarity && tif.tick && !wr_count
        |=> count_reg == 16'($past(count_reg) + 16'h0001))
        else $error("Open gate did not pass a count.");
    a_wrap_flag: assert property (  // RULE17
        s_wrap |=> overflow_flag_reg && count_reg == COUNT_RST)
        else $error("Wrap to zero did not set the overflow flag.");
    a_flag_sticky: assert property (  // RULE17
        overflow_flag_reg && !clr_ovf |=> overflow_flag_reg)
        else $error("Overflow flag dropped without a clear.");
    a_irq_follows: assert property (  // RULE11
        s_wrap ##0 irq_en_reg ##1 irq_en_reg |-> irq)
        else $error("Enabled overflow did not raise the interrupt.");

    // A count moves by exactly one on a tick and not at all without one, byte writes aside.
    a_count_step: assert property (  // RULE1
        tif.tick && !wr_count |=> count_reg == 16'($past(count_reg) + 16'h0001))
        else $error("Tick did not advance the count by one.");

    a_count_idle: assert property (  // RULE1
        !tif.tick && !wr_count |=> count_reg == $past(count_reg))
        else $error("Count moved without a tick.");

    a_flag_clear: assert property (  // RULE17
        clr_ovf && !ovf_event |=> !overflow_flag_reg)
        else $error("Overflow flag survived a clear.");

    a_read_snapshot: assert property (  // RULE12
        psel && !penable && !pwrite && paddr == OFF_COUNT_HIGH |=> prdata[7:0] == $past(count_reg[15:8]))
        else $error("High byte read did not return the count at setup.");

endmodule : gtc_timer

`default_nettype wire

//--- tb/gtc_far_side.sv
`default_nettype none

module gtc_far_side (
    input  wire logic       pclk,
    input  wire logic       start,
    input  wire logic [7:0] n,
    input  wire logic       idle,
    input  wire logic       xout,
    output logic            ext,
    output logic            lfo,
    output logic            xin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] t    = '0;
    logic [11:0] left = '0;

    // The crystal is a loop from the amplifier back to its input.
    always @(posedge pclk) begin
        t   <= t + 1'b1;
        lfo <= t[1];
        xin <= xout;
        if (start)
            left <= {1'b0, n, 3'b000};
        else if (left != 12'h000)
            left <= left - 1'b1;
    end

    // Each pulse leaves the idle level for four cycles, so idle high gives a falling edge first.
    assign ext = idle ^ ((left != 12'h000) && left[2]);
endmodule : gtc_far_side

`default_nettype wire

//--- tb/test_gated_sixteen_bit_timer_counter.sv
`default_nettype none

module test_gated_sixteen_bit_timer_counter import gtc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0, n = '0;
    logic [31:0] pwdata = '0, prdata, v, e;
    logic        pready, pslverr, xout, xin, lfo, ext, irq, eg;
    logic        go = 0, idle = 1, gate = 0, sleep = 0;
    logic [32:0] q[$];
    logic [31:0] xt[5] = '{32'h8101_1010, 32'ha101_1004, 32'h8100_0504, 32'h8303_0606, 32'h8103_0600};
    int          errors = 0, num_checks = 0, seed = 60127, k;

    initial forever #4 pclk = ~pclk;

    gtc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input(ext), .low_freq_internal_osc(lfo), .crystal_in_pin(xin),
        .crystal_out_pin(xout), .gate_input(gate), .comparator1_out(gate), .comparator2_out(~gate),
        .sleep_mode(sleep), .irq(irq));
    gtc_far_side far (.pclk(pclk), .start(go), .n(n), .idle(idle), .xout(xout), .ext(ext), .lfo(lfo),
        .xin(xin));

    // ------------------------------------------------------------------
    // Bus tasks and result checking.
    // ------------------------------------------------------------------
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata}, q.pop_front());

    // Psel drops for one cycle after each transfer, so no signal is driven twice in one step.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        q.push_back(x);
        xfer(1'b0, a, 8'h00);
    endtask : rd

    task automatic cnt(input logic [15:0] x);
        rd(OFF_COUNT_LOW, {25'h0, x[7:0]});
        rd(OFF_COUNT_HIGH, {25'h0, x[15:8]});
    endtask : cnt

    // A window of 32 + 8 * p cycles from the enabling write to the disabling write.
    task automatic run(input logic [7:0] c, input logic [7:0] p);
        wr(OFF_COUNT_LOW, 8'h00);
        wr(OFF_COUNT_HIGH, 8'h00);
        wr(OFF_CTRL, c);
        n  <= p;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (28 + 8 * p) @(posedge pclk);
        wr(OFF_CTRL, c & 8'hfe);
    endtask : run

    task automatic done(input string s);
        $display("%0t test %s done", $time, s);
    endtask : done

    task automatic print_verdict;
        errors += q.size();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    initial begin
        #200000;
        errors++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++)
            rd(8'(i * 4), {i == 7, 32'h0});
        done("reset");
        for (int i = 0; i < 3; i++) begin
            v = $random(seed);
            wr(OFF_COUNT_LOW, v[7:0]);
            wr(OFF_COUNT_HIGH, v[15:8]);
            cnt(v[15:0]);
        end
        done("bytes");
        for (int i = 0; i < 4; i++) begin
            run({GTC_SRC_SYS, 2'(i), 4'h1}, 8'h00);
            cnt(16'(32 >> i));
        end
        run({GTC_SRC_INSTR, 6'h01}, 8'h00);
        cnt(16'd8);
        done("internal");
        foreach (xt[i]) begin
            e = xt[i];
            idle  <= e[16];
            sleep <= e[17];
            run(e[31:24], e[15:8]);
            cnt({8'h00, e[7:0]});
        end
        done("external");
        wr(OFF_CTRL, 8'h04);
        k = 0;
        repeat (64) begin
            @(posedge pclk);
            if (xout !== xin)
                k++;
        end
        chk({32'h0, k > 4}, 33'h1);
        wr(OFF_CTRL, 8'h00);
        @(posedge pclk);
        chk({32'h0, xout}, 33'h0);
        sleep <= 1'b0;
        done("oscillator");
        for (int i = 0; i < 16; i++) begin
            gate <= i[0];
            wr(OFF_GATE, {4'h0, 2'(i >> 2), i[1], 1'b1});
            run(8'h41, 8'h00);
            eg = (i[3:2] == 2'd3) ? 1'b0 : i[0] ^ (i[3:2] == 2'd2);
            cnt((eg == i[1]) ? 16'd32 : 16'd0);
        end
        wr(OFF_GATE, 8'h00);
        done("gate");
        wr(OFF_IRQ_EN, 8'h01);
        wr(OFF_COUNT_LOW, 8'h00);
        wr(OFF_COUNT_HIGH, 8'hfc);
        wr(OFF_CTRL, 8'hc1);
        k = 0;
        while (irq !== 1'b1 && k < 8000) begin
            @(posedge pclk);
            k++;
        end
        wr(OFF_CTRL, 8'h00);
        chk({32'h0, irq}, 33'h1);
        wr(OFF_STATUS, 8'h00);
        rd(OFF_STATUS, 33'h1);
        wr(OFF_IRQ_EN, 8'h00);
        chk({32'h0, irq}, 33'h0);
        wr(OFF_IRQ_EN, 8'h01);
        chk({32'h0, irq}, 33'h1);
        wr(OFF_CLEAR, 8'h01);
        rd(OFF_STATUS, 33'h0);
        chk({32'h0, irq}, 33'h0);
        done("overflow");
        print_verdict();
    end
endmodule : test_gated_sixteen_bit_timer_counter

`default_nettype wire
